// ===== gci_ci_consts.vh
`ifndef GCI_CI_CONSTS_VH
`define GCI_CI_CONSTS_VH
// **********************************************
// c/i codewords
// **********************************************
`define CI_DEACT_REQ      4'h0
`define CI_RESET          4'h1
`define CI_DRIVE_AUX2     4'h2
`define CI_DRIVE_AUX1     4'h3
`define CI_RESYNC         4'h4
`define CI_ERROR          4'h5
`define CI_U_ONLY         4'h7
`define CI_ACT_REQ        4'h8
`define CI_ACT_REQ_LOOP   4'hA
`define CI_ACT_IND        4'hC
`define CI_LOOP_ACT       4'hE
`define CI_DEACT_LAST     4'hF
`define CI_IDLE_LT        4'hF
`define CI_IDLE_NT        4'h0
// **********************************************
// status fields and reset values
// **********************************************
`define ST_LINKUP         3
`define ST_SFS            1
`define ST_AIP            0
`define ST_RESET          4'h0
// **********************************************
// frame timing
// **********************************************
`define FRAMES_PER_SF     96
`define FRAME_DCL         16
`define CI_BIT_POS        4
`define FIFO_DEPTH        4
`endif

// ===== ci_fifo.v
`timescale 1ns/100ps
// **********************************************
// small fifo between line side and frame bus
// **********************************************
module ci_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wp;
   reg [AW:0]      rp;
   wire            full;
   wire            empty;
   assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign empty = (wp == rp);
   assign in_ready = !full;
   assign out_valid = !empty;
   always @* begin
      out_data = mem[rp[AW-1:0]];
   end
   always @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= {(AW+1){1'b0}};
         rp <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wp <= wp + 1'b1;
         end
         if (out_ready && !empty) begin
            rp <= rp + 1'b1;
         end
      end
   end
endmodule

// ===== gci_ci_channel_superframe_sync.v
`timescale 1ns/100ps
`include "gci_ci_consts.vh"
// Overview of operation
// - c/i codes are four bits, acted on after two equal frames
// - c/i bits numbered 4..1, bit 4 sent and received first
// - lt mode accepts dr, reset, aux2, aux1, u-only, ar, arl, dc
// - lt mode issues deact_accepted, rsy, error, uai, ar, ai, di
// - nt mode accepts reset, aux2, aux1, ar, arl, ai, di
// - nt mode issues dr, rsy, error, ar, arl, ai, loopback-active, dc
// - drive aux commands hold aux output 1 or 2 high while active
// - m4 bits handled automatically unless monitor override is set
// - issuing activation indication sets downstream act bit
// - sai set by upstream ar: never uai, keep issuing ar
// - total to u-only activation clears act bit by itself
// - nt: loopback eoc at first m4 validation gives arl not ar
// - loopback-active indication issued while 2b+d loopback lasts
// - transmitted m4 bits unchanged unless a transition changes them
// - warm start enabled only on direct enabling-state to tear-down
// - linkup, sfs and aip sit at status bits 3, 1 and 0
// - ms_select low: fsc input slave; high: master drives fsc
// - fsc normally two dcl; one dcl pulse every 96 frames aligns
// - 2b+d after single-clock fsc is first of the superframe
// - without alignment pulse the device picks alignment itself
// - master outputs one-dcl fsc on first 2b+d, every 96 frames
// - nt slave ignores fsc alignment; lt fsc stable before activation
module gci_ci_channel_superframe_sync #(
   parameter FRAMES_PER_SF = `FRAMES_PER_SF,
   parameter FRAME_DCL     = `FRAME_DCL
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       lt_mode,
   input  wire       ms_select,
   input  wire       dcl,
   input  wire       fsc_in,
   output reg        fsc_out,
   output wire       fsc_oe,
   input  wire       din,
   output reg        dout,
   input  wire [7:0] line_data,
   input  wire       line_valid,
   output wire       line_ready,
   output reg  [7:0] bd_data,
   output reg        bd_valid,
   output reg        sf_align,
   input  wire       link_up,
   input  wire       sfs_in,
   input  wire       aip_in,
   input  wire       act_up,
   input  wire       sai_up,
   input  wire       loop_eoc,
   input  wire       m4_valid,
   input  wire       loop_active,
   input  wire       err_in,
   input  wire       resync_in,
   input  wire       m4_override,
   input  wire [7:0] m4_manual,
   input  wire       warm_enable_state,
   input  wire       tear_down,
   output reg  [3:0] ci_cmd,
   output reg        cmd_strobe,
   output reg        aux_output_1,
   output reg        aux_output_2,
   output reg  [7:0] m4_tx,
   output reg        warm_start,
   output reg  [3:0] status_reg_1
);
   // **********************************************
   // reset and input synchronisers
   // **********************************************
   reg       rst_a;
   reg       rst_s;
   reg [1:0] dcl_s;
   reg [1:0] fsc_s;
   reg [1:0] din_s;
   reg [1:0] ms_s;
   reg       dcl_d;
   wire      dcl_rise;
   wire      dcl_fall;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_a <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_s <= rst_a;
      end
   end
   // first stages feed only their second stages
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         dcl_s <= 2'b00;
         fsc_s <= 2'b00;
         din_s <= 2'b00;
         ms_s  <= 2'b00;
         dcl_d <= 1'b0;
      end else begin
         dcl_s <= {dcl_s[0], dcl};
         fsc_s <= {fsc_s[0], fsc_in};
         din_s <= {din_s[0], din};
         ms_s  <= {ms_s[0], ms_select};
         dcl_d <= dcl_s[1];
      end
   end
   assign dcl_rise = dcl_s[1] & ~dcl_d;
   assign dcl_fall = ~dcl_s[1] & dcl_d;
   wire master;
   assign master = ms_s[1];
   assign fsc_oe = master;

   // **********************************************
   // frame timing on dcl edges
   // **********************************************
   reg [4:0] bitcnt;
   reg [6:0] frame;
   reg [1:0] fsc_len;
   reg       fsc_hi;
   reg       aligned_ext;
   wire      frame_start;
   wire      slave_fsc;
   assign slave_fsc = ~master & fsc_s[1];
   // fsc is sampled at dcl rise, slave timing relies on synchronous fsc
   assign frame_start = master ? (dcl_rise && bitcnt == 5'd0) :
                        (dcl_rise && slave_fsc && !fsc_hi);
   function [6:0] inc_wrap;
      input [6:0] v;
      input [6:0] lim;
      begin
         inc_wrap = (v == lim - 7'd1) ? 7'd0 : v + 7'd1;
      end
   endfunction
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         bitcnt      <= 5'd0;
         frame       <= 7'd0;
         fsc_len     <= 2'd0;
         fsc_hi      <= 1'b0;
         aligned_ext <= 1'b0;
         sf_align    <= 1'b0;
         fsc_out     <= 1'b0;
      end else begin
         sf_align <= 1'b0;
         if (dcl_rise) begin
            fsc_hi <= slave_fsc;
            if (frame_start) begin
               bitcnt <= 5'd1;
               frame  <= inc_wrap(frame, FRAMES_PER_SF[6:0]);
            end else if (bitcnt == FRAME_DCL[4:0] - 5'd1) begin
               bitcnt <= 5'd0;
            end else begin
               bitcnt <= bitcnt + 5'd1;
            end
            if (slave_fsc) begin
               fsc_len <= (fsc_len == 2'd3) ? 2'd3 : fsc_len + 2'd1;
            end else begin
               fsc_len <= 2'd0;
               // one-dcl pulse forces alignment in lt slave only
               if (fsc_len == 2'd1 && lt_mode) begin
                  frame       <= 7'd1;
                  aligned_ext <= 1'b1;
                  sf_align    <= 1'b1;
               end
            end
            // master: one-dcl pulse on superframe start, else two
            if (master) begin
               if (frame_start) begin
                  fsc_out <= 1'b1;
               end else if (bitcnt == 5'd1 && frame != 7'd1) begin
                  fsc_out <= 1'b1;
               end else begin
                  fsc_out <= 1'b0;
               end
            end else begin
               fsc_out <= 1'b0;
            end
         end
      end
   end

   // **********************************************
   // c/i receive, msb first, two-frame persistence
   // **********************************************
   reg [3:0] ci_sh;
   reg [3:0] ci_prev;
   reg       ci_seen;
   reg [3:0] ci_tx;
   wire      ci_slot;
   wire      ci_end;
   assign ci_slot = bitcnt >= `CI_BIT_POS && bitcnt < `CI_BIT_POS + 4;
   assign ci_end  = dcl_fall && bitcnt == `CI_BIT_POS + 4;
   function accepted;
      input [3:0] c;
      input       lt;
      begin
         case (c)
            `CI_RESET, `CI_DRIVE_AUX2, `CI_DRIVE_AUX1,
            `CI_ACT_REQ, `CI_ACT_REQ_LOOP, `CI_DEACT_LAST:
               accepted = 1'b1;
            `CI_DEACT_REQ, `CI_U_ONLY: accepted = lt;
            `CI_ACT_IND: accepted = ~lt;
            default: accepted = 1'b0;
         endcase
      end
   endfunction
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         ci_sh        <= 4'h0;
         ci_prev      <= 4'h0;
         ci_seen      <= 1'b0;
         ci_cmd       <= 4'hF;
         cmd_strobe   <= 1'b0;
         aux_output_1 <= 1'b0;
         aux_output_2 <= 1'b0;
         dout         <= 1'b1;
      end else begin
         cmd_strobe <= 1'b0;
         if (dcl_fall && ci_slot) begin
            ci_sh <= {ci_sh[2:0], din_s[1]};
         end
         if (dcl_rise) begin
            // bit 4 of the indication goes out first
            dout <= ci_slot ? ci_tx[3 - (bitcnt[1:0])] : 1'b1;
         end
         if (ci_end) begin
            ci_prev <= ci_sh;
            ci_seen <= (ci_sh == ci_prev);
            if (ci_sh == ci_prev && !ci_seen && accepted(ci_sh, lt_mode)) begin
               ci_cmd     <= ci_sh;
               cmd_strobe <= 1'b1;
            end
         end
         aux_output_1 <= ci_cmd == `CI_DRIVE_AUX1;
         aux_output_2 <= ci_cmd == `CI_DRIVE_AUX2;
      end
   end

   // **********************************************
   // indications and m4 handling
   // **********************************************
   reg [3:0] next_ci_tx;
   reg       sai_by_ar;
   reg       total_act;
   reg       tear_d;
   reg       warm_d;
   always @* begin
      next_ci_tx = lt_mode ? `CI_IDLE_LT : `CI_IDLE_NT;
      if (lt_mode) begin
         if (err_in) next_ci_tx = `CI_ERROR;
         else if (resync_in) next_ci_tx = `CI_RESYNC;
         else if (ci_cmd == `CI_RESET) next_ci_tx = `CI_RESET;
         else if (link_up && act_up) next_ci_tx = `CI_ACT_IND;
         else if (link_up && (sai_up || sai_by_ar))
            next_ci_tx = `CI_ACT_REQ;
         else if (link_up) next_ci_tx = `CI_U_ONLY;
         else if (aip_in) next_ci_tx = `CI_ACT_REQ;
         else next_ci_tx = `CI_DEACT_LAST;
      end else begin
         if (err_in) next_ci_tx = `CI_ERROR;
         else if (resync_in) next_ci_tx = `CI_RESYNC;
         else if (loop_active) next_ci_tx = `CI_LOOP_ACT;
         else if (link_up && act_up) next_ci_tx = `CI_ACT_IND;
         else if (link_up && m4_valid)
            next_ci_tx = loop_eoc ? `CI_ACT_REQ_LOOP : `CI_ACT_REQ;
         else if (ci_cmd == `CI_DEACT_LAST) next_ci_tx = `CI_DEACT_LAST;
         else next_ci_tx = `CI_DEACT_REQ;
      end
   end
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         ci_tx     <= 4'hF;
         sai_by_ar <= 1'b0;
      end else begin
         // the code only changes at a frame edge, never inside the slot
         if (frame_start) begin
            ci_tx <= next_ci_tx;
         end
         if (!link_up) begin
            sai_by_ar <= 1'b0;
         end else if (ci_cmd == `CI_ACT_REQ && sai_up) begin
            sai_by_ar <= 1'b1;
         end
      end
   end

   // **********************************************
   // transmitted m4 bits
   // **********************************************
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         total_act <= 1'b0;
         m4_tx     <= 8'hFF;
      end else begin
         total_act <= ci_tx == `CI_ACT_IND;
         // m4 only changes on the transitions below
         if (m4_override) begin
            m4_tx <= m4_manual;
         end else if (ci_tx == `CI_ACT_IND && !total_act) begin
            m4_tx[7] <= 1'b1;
         end else if (total_act && ci_tx == `CI_U_ONLY) begin
            m4_tx[7] <= 1'b0;
         end else if (!link_up) begin
            m4_tx <= 8'hFF;
         end
      end
   end

   // **********************************************
   // warm start tracking
   // **********************************************
   // the enabling state is looked at one cycle back, so a direct
   // step into tear-down still sees the state it came from
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         tear_d     <= 1'b0;
         warm_d     <= 1'b0;
         warm_start <= 1'b0;
      end else begin
         tear_d <= tear_down;
         warm_d <= warm_enable_state;
         if (tear_down && !tear_d) begin
            warm_start <= warm_d;
         end else if (!tear_down && tear_d) begin
            warm_start <= warm_start;
         end else if (!tear_down && !warm_enable_state) begin
            warm_start <= 1'b0;
         end
      end
   end

   // **********************************************
   // status register
   // **********************************************
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         status_reg_1 <= `ST_RESET;
      end else begin
         status_reg_1[`ST_LINKUP] <= link_up;
         status_reg_1[2]          <= 1'b0;
         status_reg_1[`ST_SFS]    <= sfs_in | aligned_ext;
         status_reg_1[`ST_AIP]    <= aip_in;
      end
   end

   // **********************************************
   // line data buffer toward the frame bus
   // **********************************************
   wire [7:0] fifo_data;
   wire       fifo_valid;
   wire       take;
   // b-channel slot drains one word per frame; fifo stalls the line side
   assign take = frame_start && fifo_valid;
   ci_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_s),
      .in_data   (line_data),
      .in_valid  (line_valid),
      .in_ready  (line_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (take)
   );
   always @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         bd_data  <= 8'h00;
         bd_valid <= 1'b0;
      end else begin
         bd_valid <= take;
         if (take) begin
            bd_data <= fifo_data;
         end
      end
   end
endmodule

// ===== gci_ci_props.sv
`timescale 1ns/100ps
`include "gci_ci_consts.vh"
// ****************************
// port checker
// ****************************
module gci_ci_props (
   input wire       clk,
   input wire       rst_n,
   input wire       lt_mode,
   input wire       ms_select,
   input wire       fsc_oe,
   input wire       link_up,
   input wire       m4_override,
   input wire [7:0] m4_manual,
   input wire       warm_enable_state,
   input wire       tear_down,
   input wire [3:0] ci_cmd,
   input wire       cmd_strobe,
   input wire       aux_output_1,
   input wire       aux_output_2,
   input wire [7:0] m4_tx,
   input wire       warm_start,
   input wire [3:0] status_reg_1
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_aux1_high: assert property ((ci_cmd == `CI_DRIVE_AUX1)[*2] |-> aux_output_1)
      else $error("aux output 1 low during drive command");
   a_aux1_low: assert property ((ci_cmd != `CI_DRIVE_AUX1)[*2] |-> !aux_output_1)
      else $error("aux output 1 high without drive command");
   a_aux2_high: assert property ((ci_cmd == `CI_DRIVE_AUX2)[*2] |-> aux_output_2)
      else $error("aux output 2 low during drive command");
   a_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
      else $error("command strobe longer than one cycle");
   // a code change without a strobe means the persistence check was skipped
   a_cmd_strobed: assert property (!$stable(ci_cmd) |-> cmd_strobe || $past(cmd_strobe))
      else $error("command changed without strobe");
   a_lt_accept: assert property (cmd_strobe && lt_mode |=>
      ci_cmd inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'hA, 4'hF})
      else $error("lt mode accepted a foreign code");
   a_nt_accept: assert property (cmd_strobe && !lt_mode |=>
      ci_cmd inside {4'h1, 4'h2, 4'h3, 4'h8, 4'hA, 4'hC, 4'hF})
      else $error("nt mode accepted a foreign code");
   a_status_link: assert property ($rose(link_up) |-> ##[1:4] status_reg_1[3])
      else $error("linkup flag not in status bit 3");
   // eight cycles cover the internal reset release plus the pin synchroniser
   a_master_oe: assert property (ms_select[*8] |-> fsc_oe)
      else $error("master mode not driving fsc");
   a_warm_clear: assert property ((!warm_enable_state && !tear_down)[*3] |-> !warm_start)
      else $error("warm start kept without tear-down");
   a_m4_manual: assert property ((m4_override && $stable(m4_manual))[*4] |-> m4_tx == m4_manual)
      else $error("m4 override not applied");
endmodule
bind gci_ci_channel_superframe_sync gci_ci_props chk (.clk(clk), .rst_n(rst_n),
   .lt_mode(lt_mode), .ms_select(ms_select), .fsc_oe(fsc_oe), .link_up(link_up),
   .m4_override(m4_override), .m4_manual(m4_manual), .tear_down(tear_down),
   .warm_enable_state(warm_enable_state), .ci_cmd(ci_cmd),
   .cmd_strobe(cmd_strobe), .aux_output_1(aux_output_1),
   .aux_output_2(aux_output_2), .m4_tx(m4_tx), .warm_start(warm_start),
   .status_reg_1(status_reg_1));

// ===== gci_layer2_model.sv
`timescale 1ns/100ps
// ****************************
// frame bus peer
// ****************************
module gci_layer2_model (
   input  wire [3:0] code,
   input  wire [3:0] alt_code,
   input  wire       alt,
   input  wire       one_pulse,
   input  wire       dout,
   output reg        dcl,
   output reg        fsc,
   output reg        din,
   output reg  [3:0] ind
);
   integer   bitn;
   reg [3:0] cur;
   reg       flip;
   // code latched at frame start so a frame never carries two codes
   initial begin
      dcl = 0; fsc = 0; din = 1; ind = 0; bitn = 0; flip = 0; cur = 4'hF;
      forever begin
         if (bitn == 0) begin
            cur = (alt && flip) ? alt_code : code;
            flip = !flip;
         end
         fsc = (bitn == 0) || (bitn == 1 && !one_pulse);
         // the block takes the code one dcl ahead of its answer slot
         din = (bitn >= 3 && bitn <= 6) ? cur[6 - bitn] : 1'b1;
         dcl = 1;
         #400;
         dcl = 0;
         if (bitn >= 4 && bitn <= 7)
            ind[7 - bitn] = dout;
         #400;
         bitn = (bitn + 1) % 16;
      end
   end
endmodule

// ===== tb_gci_ci_channel_superframe_sync.sv
`timescale 1ns/100ps
// ****************************
// testbench
// ****************************
module tb_gci_ci_channel_superframe_sync;
   logic       clk, rst_n, lt_mode, ms_select, line_valid, link_up, sfs_in;
   logic       aip_in, loop_active, err_in, m4_override, warm_enable_state;
   logic       tear_down, alt, one_pulse, act_up, sai_up, loop_eoc;
   logic       m4_valid, resync_in;
   logic [7:0] line_data, m4_manual;
   logic [3:0] code, alt_code;
   wire        dcl, fsc, din, dout, fsc_out, fsc_oe, line_ready, bd_valid;
   wire        sf_align, cmd_strobe, aux_output_1, aux_output_2, warm_start;
   wire  [7:0] bd_data, m4_tx;
   wire  [3:0] ci_cmd, status_reg_1, ind;
   logic [7:0] got [0:7];
   logic       fsc_prev;
   integer     num_errors, compares, i, nbd, sf_seen, fsc_rises;
   logic [10:0] r;
   // row: mode, code sent, command expected, aux 1, aux 2
   localparam logic [10:0] rows [19] = '{11'h4CE, 11'h489, 11'h509, 11'h620,
      11'h5DC, 11'h6A8, 11'h400, 11'h444, 11'h704, 11'h7FC, 11'h0CE, 11'h089,
      11'h009, 11'h220, 11'h2A8, 11'h330, 11'h044, 11'h1C4, 11'h3FC};
   gci_ci_channel_superframe_sync uut (.clk(clk), .rst_n(rst_n),
      .lt_mode(lt_mode), .ms_select(ms_select), .dcl(dcl), .fsc_in(fsc),
      .fsc_out(fsc_out), .fsc_oe(fsc_oe), .din(din), .dout(dout),
      .line_data(line_data), .line_valid(line_valid), .line_ready(line_ready),
      .bd_data(bd_data), .bd_valid(bd_valid), .sf_align(sf_align),
      .link_up(link_up), .sfs_in(sfs_in), .aip_in(aip_in), .act_up(act_up),
      .sai_up(sai_up), .loop_eoc(loop_eoc), .m4_valid(m4_valid),
      .loop_active(loop_active), .err_in(err_in), .resync_in(resync_in),
      .m4_override(m4_override), .m4_manual(m4_manual),
      .warm_enable_state(warm_enable_state), .tear_down(tear_down),
      .ci_cmd(ci_cmd), .cmd_strobe(cmd_strobe), .aux_output_1(aux_output_1),
      .aux_output_2(aux_output_2), .m4_tx(m4_tx), .warm_start(warm_start),
      .status_reg_1(status_reg_1));
   gci_layer2_model peer (.code(code), .alt_code(alt_code), .alt(alt),
      .one_pulse(one_pulse), .dout(dout), .dcl(dcl), .fsc(fsc), .din(din),
      .ind(ind));
   initial begin
      clk = 0;
      forever #50 clk = !clk;
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task complete_run;
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task wclk(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task align(input logic lt, input integer exp);
      lt_mode = lt;
      sf_seen = 0;
      one_pulse = 1;
      wclk(150);
      one_pulse = 0;
      wclk(150);
      check(sf_seen, exp);
   endtask
   always @(posedge clk) begin
      if (sf_align === 1'b1) sf_seen <= 1;
      if (bd_valid === 1'b1 && nbd < 8) begin
         got[nbd] <= bd_data;
         nbd <= nbd + 1;
      end
      fsc_prev <= fsc_out;
      if (fsc_out === 1'b1 && fsc_prev === 1'b0) fsc_rises <= fsc_rises + 1;
   end
   initial begin
      #3000000;
      num_errors++;
      complete_run;
   end
   initial begin
      num_errors = 0; compares = 0; nbd = 0; sf_seen = 0; fsc_rises = 0;
      rst_n = 0; lt_mode = 1; ms_select = 0; line_valid = 0; link_up = 0;
      sfs_in = 0; aip_in = 0; loop_active = 0; err_in = 0; m4_override = 0;
      warm_enable_state = 0; tear_down = 0; alt = 0; one_pulse = 0;
      line_data = 8'h00; m4_manual = 8'h00; code = 4'hF; alt_code = 4'hF;
      act_up = 0; sai_up = 0; loop_eoc = 0; m4_valid = 0; resync_in = 0;
      wclk(12);
      rst_n = 1;
      wclk(3);
      check(ci_cmd, 4'hF);
      check(m4_tx, 8'hFF);
      check(status_reg_1, 4'h0);
      for (i = 0; i < 19; i++) begin
         r = rows[i];
         lt_mode = r[10];
         code = r[9:6];
         wclk(450);
         check(ci_cmd, r[5:2]);
         check(aux_output_1, r[1]);
         check(aux_output_2, r[0]);
      end
      // alternating codes never repeat in two frames, so nothing is taken
      lt_mode = 1; code = 4'h3; alt_code = 4'h2; alt = 1;
      wclk(900);
      check(ci_cmd, 4'hF);
      alt = 0; code = 4'hF; lt_mode = 0; loop_active = 1;
      wclk(450);
      check(ind, 4'hE);
      loop_active = 0; lt_mode = 1; err_in = 1;
      wclk(450);
      check(ind, 4'h5);
      err_in = 0; resync_in = 1;
      wclk(450);
      check(ind, 4'h4);
      resync_in = 0; link_up = 1; sai_up = 1;
      wclk(450);
      check(ind, 4'h8);
      sai_up = 0; act_up = 1;
      wclk(450);
      check(ind, 4'hC);
      act_up = 0;
      wclk(450);
      check(ind, 4'h7);
      check(m4_tx[7], 1'b0);
      act_up = 1;
      wclk(450);
      check(m4_tx[7], 1'b1);
      act_up = 0; lt_mode = 0; m4_valid = 1; loop_eoc = 1;
      wclk(450);
      check(ind, 4'hA);
      m4_valid = 0; loop_eoc = 0; lt_mode = 1;
      err_in = 0; link_up = 1; sfs_in = 1;
      wclk(6);
      check(status_reg_1, 4'hA);
      link_up = 0; sfs_in = 0; aip_in = 1;
      wclk(6);
      check(status_reg_1, 4'h1);
      aip_in = 0; m4_override = 1; m4_manual = 8'hA5;
      wclk(8);
      check(m4_tx, 8'hA5);
      m4_override = 0; warm_enable_state = 1;
      wclk(4);
      warm_enable_state = 0; tear_down = 1;
      wclk(4);
      check(warm_start, 1'b1);
      tear_down = 0;
      wclk(4);
      check(warm_start, 1'b0);
      align(1'b1, 1);
      align(1'b0, 0);
      ms_select = 1;
      wclk(8);
      check(fsc_oe, 1'b1);
      fsc_rises = 0;
      wclk(300);
      check(fsc_rises != 0, 1'b1);
      ms_select = 0;
      wclk(8);
      check(fsc_oe, 1'b0);
      // fill just after a frame start so no word drains while filling
      @(negedge fsc);
      wclk(10);
      nbd = 0;
      for (i = 0; i < 5; i++) begin
         line_valid = 1;
         line_data = 8'h11 * (i + 1);
         wclk(1);
      end
      line_valid = 0;
      check(line_ready, 1'b0);
      wclk(700);
      check(nbd, 4);
      for (i = 0; i < 4; i++)
         check(got[i], 8'h11 * (i + 1));
      complete_run;
   end
endmodule
